// >>> dv/retimer_channel_status_irq_bench.sv
// Purpose: Self-checking bench for the channel status, event flag and interrupt block.
// Assumes: One wait state per transfer; register byte address is four times its index.
// Notes: Register rows run first, then hand-written event, load, stall and reset cases.
`timescale 1ns/10ps
`default_nettype none
`include "retimer_consts.svh"
module retimer_channel_status_irq_bench;
  import retimer_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] ex;
  } row_t;
  logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sig_pin, lock_pin, eye_req, adapt_busy, nv_load, chk_en_o, gen_en_o;
  logic [7:0] nv_thr;
  logic [1:0] nv_en;
  eye_sample_t eye_sample;
  int fail_count, samples_checked, cycles;
  row_t rows [11];

  // The register port's ready feeds the bus ready, as the only slave.
  retimer_channel_status_irq dut_u (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .signal_present_pin(sig_pin), .clock_recovery_locked_pin(lock_pin),
    .eye_measure_request(eye_req), .adaptation_busy(adapt_busy),
    .eye_sample(eye_sample), .nv_load(nv_load), .nv_thresholds(nv_thr),
    .nv_enables(nv_en), .pattern_checker_enable(chk_en_o),
    .pattern_generator_enable(gen_en_o), .irq(irq)
  );

  // Clock generation at 200 MHz.
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Hang guard: a run past the ceiling counts as a mismatch.
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      results();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares a register read word against an expected byte.
  task automatic chk_reg(input logic [31:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== {24'h0000_00, e}) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, {24'h0000_00, e});
    end
  endtask

  // Compares a single output pin against an expected level.
  task automatic chk_pin(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One single word transfer: address phase, then data phase, each held until ready.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    haddr <= {22'h00_0000, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0000_00, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Write helper.
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask

  // Read helper that compares the returned word.
  task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk_reg(d, ex);
  endtask

  // Presents one eye measurement for a single cycle.
  task automatic eye(input logic [3:0] h, input logic [3:0] v);
    @(posedge hclk);
    eye_sample <= {1'b1, h, v};
    @(posedge hclk);
    eye_sample.valid <= 1'b0;
  endtask

  // Main sequence: reset, register rows, then the awkward cases.
  initial begin
    {hresetn, hsel, hwrite, nv_load, sig_pin, lock_pin, eye_req, adapt_busy} = '0;
    clk_en = 1'b1;
    {haddr, hwdata} = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    eye_sample = '0;
    nv_thr = 8'h00;
    nv_en = 2'b00;
    {fail_count, samples_checked, cycles} = '0;
    rows = '{
      '{1'b0, `IDX_THRESH, 8'h00, 8'h21},
      '{1'b0, `IDX_CTRL, 8'h00, 8'h10},
      '{1'b0, `IDX_SPARE, 8'h00, 8'h00},
      '{1'b0, `IDX_STATUS, 8'h00, 8'h00},
      '{1'b1, `IDX_THRESH, 8'hA5, 8'hA5},
      '{1'b1, `IDX_SPARE, 8'hFF, 8'hFF},
      '{1'b1, `IDX_CTRL, 8'h70, 8'h70},
      '{1'b1, `IDX_STATUS, 8'hFF, 8'h00},
      '{1'b1, 8'hFF, 8'h5A, 8'h00},
      '{1'b1, `IDX_IRQ_MASK, 8'h04, 8'h04},
      '{1'b1, `IDX_EYE_CFG, 8'h01, 8'h01}
    };
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk_pin(irq, 1'b0);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].idx, rows[i].wd);
      end
      rd(rows[i].idx, rows[i].ex);
    end
    chk_pin(chk_en_o, 1'b1);
    chk_pin(gen_en_o, 1'b1);
    wr(`IDX_CTRL, 8'h10);
    chk_pin(chk_en_o, 1'b0);
    chk_pin(gen_en_o, 1'b0);
    $display("test done: register rows");
    // Signal detect changes in both directions, then with the flag gated off.
    wr(`IDX_CTRL, 8'h11);
    sig_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(`IDX_STATUS, 8'h24);
    rd(`IDX_STATUS, 8'h20);
    sig_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(`IDX_STATUS, 8'h04);
    rd(`IDX_STATUS, 8'h00);
    wr(`IDX_CTRL, 8'h10);
    sig_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(`IDX_STATUS, 8'h20);
    $display("test done: signal detect");
    // Lock rise sets the flag, a fall does not, and the gate suppresses it.
    wr(`IDX_CTRL, 8'h12);
    lock_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(`IDX_STATUS, 8'h38);
    rd(`IDX_STATUS, 8'h30);
    lock_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(`IDX_STATUS, 8'h20);
    wr(`IDX_CTRL, 8'h10);
    lock_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(`IDX_STATUS, 8'h30);
    $display("test done: lock");
    // Eye thresholds are vertical 0xA and horizontal 0x5; equal values do not trip.
    eye(4'h5, 4'hA);
    rd(`IDX_STATUS, 8'h30);
    chk_pin(irq, 1'b0);
    eye(4'h4, 4'hF);
    @(posedge hclk);
    chk_pin(irq, 1'b1);
    rd(`IDX_STATUS, 8'h31);
    eye(4'hF, 4'h9);
    rd(`IDX_STATUS, 8'h31);
    // Lock and detect events from the earlier tests are still pending here.
    rd(`IDX_IRQ_STAT, 8'h07);
    chk_pin(irq, 1'b0);
    // An eye event lands in the same cycle as the clearing read.
    fork
      rd(`IDX_STATUS, 8'h30);
      begin
        repeat (2) @(posedge hclk);
        eye_sample <= {1'b1, 4'h0, 4'h0};
        @(posedge hclk);
        eye_sample.valid <= 1'b0;
      end
    join
    rd(`IDX_STATUS, 8'h31);
    rd(`IDX_IRQ_STAT, 8'h04);
    $display("test done: eye flag and interrupt");
    // Range error follows request during adaptation; its interrupt bit is masked.
    eye_req <= 1'b1;
    adapt_busy <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(`IDX_STATUS, 8'h32);
    adapt_busy <= 1'b0;
    repeat (2) @(posedge hclk);
    rd(`IDX_STATUS, 8'h30);
    chk_pin(irq, 1'b0);
    rd(`IDX_IRQ_STAT, 8'h08);
    $display("test done: range error");
    // Nonvolatile load reaches thresholds and flag enables but not the checker bit.
    wr(`IDX_CTRL, 8'h50);
    @(posedge hclk);
    nv_thr <= 8'h5C;
    nv_en <= 2'b11;
    nv_load <= 1'b1;
    @(posedge hclk);
    nv_load <= 1'b0;
    rd(`IDX_THRESH, 8'h5C);
    rd(`IDX_CTRL, 8'h53);
    $display("test done: nonvolatile load");
    // Clock enable low stalls the port; response stays OKAY.
    @(posedge hclk);
    clk_en <= 1'b0;
    @(negedge hclk);
    chk_pin(hreadyout, 1'b0);
    chk_pin(hresp, 1'b0);
    @(posedge hclk);
    clk_en <= 1'b1;
    // Second reset in mid-run restores the enables.
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk_pin(chk_en_o, 1'b0);
    chk_pin(irq, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(`IDX_CTRL, 8'h10);
    repeat (3) @(posedge hclk);
    rd(`IDX_STATUS, 8'h30);
    $display("test done: stall and reset");
    results();
  end
endmodule
`default_nettype wire

// >>> rtl/ahb_reg_port.sv
// Purpose: AHB-Lite slave front end turning transfers into register accesses.
// Assumes: Single word transfers; every transfer takes one wait state while clk_en is high, more while it is low.
// Notes: Non-word or out-of-range transfers are unmapped; reads return zero.
`timescale 1ns/10ps
`default_nettype none
module ahb_reg_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] rdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output retimer_pkg::reg_access_t access,
  output logic [31:0] wdata
);
  import retimer_pkg::*;

  bus_phase_t phase_r;
  logic take;
  logic write_r;
  logic mapped_r;
  logic [7:0] index_r;

  // An address phase is taken on NONSEQ or SEQ while the bus is ready.
  assign take = clk_en & hsel & htrans[1] & hready;
  assign hreadyout = clk_en & (phase_r != ph_wait);
  assign hresp = 1'b0;
  assign access = '{valid: clk_en & (phase_r == ph_wait), write: write_r,
                    mapped: mapped_r, index: index_r};
  assign wdata = hwdata;

  // Phase sequencing: idle, one wait cycle, then the completing cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= ph_idle;
    end else if (clk_en) begin
      unique case (phase_r)
        ph_idle: phase_r <= take ? ph_wait : ph_idle;
        ph_wait: phase_r <= ph_done;
        ph_done: phase_r <= take ? ph_wait : ph_idle;
        default: phase_r <= ph_idle;
      endcase
    end
  end

  // Address capture.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_r <= 1'b0;
      mapped_r <= 1'b0;
      index_r <= 8'h00;
    end else if (take) begin
      write_r <= hwrite;
      mapped_r <= (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00) &&
                  (hsize == 3'b010);
      index_r <= haddr[9:2];
    end
  end

  // Read data is registered at the end of the wait cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (access.valid && !write_r) begin
      hrdata <= rdata;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/bit_sync2.sv
// Purpose: Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes: Inputs are slow levels.
// Notes: The first stage feeds only the second.
`timescale 1ns/10ps
`default_nettype none
module bit_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // Two stages, both frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/retimer_channel_status_irq.sv
// Purpose: Channel status, sticky event flags, enables and interrupt of one retimer channel.
// Assumes: Signal detect and lock come from other domains; eye and adaptation
// signals come from logic on hclk.
// Notes: Registers sit at byte address four times their index.
`timescale 1ns/10ps
`default_nettype none
`include "retimer_consts.svh"

module retimer_channel_status_irq (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic signal_present_pin,
  input wire logic clock_recovery_locked_pin,
  input wire logic eye_measure_request,
  input wire logic adaptation_busy,
  input wire retimer_pkg::eye_sample_t eye_sample,
  input wire logic nv_load,
  input wire logic [7:0] nv_thresholds,
  input wire logic [1:0] nv_enables,
  output logic pattern_checker_enable,
  output logic pattern_generator_enable,
  output logic irq
);
  import retimer_pkg::*;

  reg_access_t acc;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0] live_s;
  logic signal_present_live;
  logic clock_recovery_locked_live;
  logic sd_prev_r;
  logic lock_prev_r;
  logic [7:0] thresh_r;
  logic [7:0] ctrl_r;
  logic [7:0] spare_r;
  logic eye_flag_enable_r;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic eye_range_limit_error_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_stat_nxt;
  logic [3:0] irq_mask_r;
  logic lock_rise;
  logic sd_change;
  logic eye_low;
  logic range_rise;
  logic set_lock;
  logic set_sd;
  logic set_eye;
  logic clr_status;
  logic clr_irq;
  logic [7:0] status_byte;

  // True when the access is valid, mapped and aimed at the given index.
  function automatic logic hit(input reg_access_t a, input logic [7:0] idx);
    hit = a.valid && a.mapped && (a.index == idx);
  endfunction

  // True when either eye opening lies below its threshold.
  function automatic logic eye_below(input eye_sample_t s, input logic [7:0] thr);
    eye_below = (s.vertical < thr[7:4]) || (s.horizontal < thr[3:0]);
  endfunction

  // Bus front end; transfers complete with one wait state while clk_en stays high, and clk_en low adds wait states.
  ahb_reg_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .rdata(rdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .access(acc),
    .wdata(wdata)
  );

  // Signal detect and lock arrive from the analog side and are synchronised.
  bit_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .clk_en(clk_en),
    .d({signal_present_pin, clock_recovery_locked_pin}),
    .q(live_s)
  );

  assign signal_present_live = live_s[1];
  assign clock_recovery_locked_live = live_s[0];

  // Previous synchronised levels for edge detection.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sd_prev_r <= 1'b0;
      lock_prev_r <= 1'b0;
    end else if (clk_en) begin
      sd_prev_r <= signal_present_live;
      lock_prev_r <= clock_recovery_locked_live;
    end
  end

  // Event detection; lock, detect and eye events each gated by its own enable, range error ungated.
  assign lock_rise = clock_recovery_locked_live & ~lock_prev_r;
  assign sd_change = signal_present_live ^ sd_prev_r;
  assign eye_low = eye_sample.valid & clock_recovery_locked_live &
                   eye_below(eye_sample, thresh_r);
  assign set_lock = clk_en & lock_rise & ctrl_r[`CT_LOCK_EN];
  assign set_sd = clk_en & sd_change & ctrl_r[`CT_SD_EN];
  assign set_eye = clk_en & eye_low & eye_flag_enable_r;
  assign range_rise = clk_en & eye_measure_request & adaptation_busy &
                      ~eye_range_limit_error_r;
  assign clr_status = hit(acc, `IDX_STATUS) && !acc.write;
  assign clr_irq = hit(acc, `IDX_IRQ_STAT) && !acc.write;

  // Sticky flags: reading clears, a same-cycle event wins over the clear.
  always_comb begin
    flags_nxt = flags_r;
    if (clr_status) begin
      flags_nxt = 3'b000;
    end
    if (set_lock) begin
      flags_nxt[2] = 1'b1;
    end
    if (set_sd) begin
      flags_nxt[1] = 1'b1;
    end
    if (set_eye) begin
      flags_nxt[0] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= 3'b000;
    end else if (clk_en) begin
      flags_r <= flags_nxt;
    end
  end

  // Range limit error follows request during adaptation, one cycle late.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eye_range_limit_error_r <= 1'b0;
    end else if (clk_en) begin
      eye_range_limit_error_r <= eye_measure_request & adaptation_busy;
    end
  end

  // Enable register; nonvolatile load only touches the two flag enables.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `RST_CTRL;
    end else if (clk_en) begin
      if (hit(acc, `IDX_CTRL) && acc.write) begin
        ctrl_r <= wdata[7:0];
      end else if (nv_load) begin
        ctrl_r[1:0] <= nv_enables;
      end
    end
  end

  // Threshold register, also loadable from nonvolatile storage.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thresh_r <= `RST_THRESH;
    end else if (clk_en) begin
      if (hit(acc, `IDX_THRESH) && acc.write) begin
        thresh_r <= wdata[7:0];
      end else if (nv_load) begin
        thresh_r <= nv_thresholds;
      end
    end
  end

  // Spare register and eye flag enable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spare_r <= `RST_SPARE;
      eye_flag_enable_r <= 1'b0;
    end else if (clk_en) begin
      if (hit(acc, `IDX_SPARE) && acc.write) begin
        spare_r <= wdata[7:0];
      end
      if (hit(acc, `IDX_EYE_CFG) && acc.write) begin
        eye_flag_enable_r <= wdata[0];
      end
    end
  end

  // Interrupt status: set by the flag events and range rise, cleared on read, set wins.
  always_comb begin
    irq_stat_nxt = clr_irq ? 4'h0 : irq_stat_r;
    irq_stat_nxt[`IRQ_LOCK] = irq_stat_nxt[`IRQ_LOCK] | set_lock;
    irq_stat_nxt[`IRQ_SD] = irq_stat_nxt[`IRQ_SD] | set_sd;
    irq_stat_nxt[`IRQ_EYE] = irq_stat_nxt[`IRQ_EYE] | set_eye;
    irq_stat_nxt[`IRQ_RANGE] = irq_stat_nxt[`IRQ_RANGE] | range_rise;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= 4'h0;
      irq_mask_r <= `RST_MASK;
    end else if (clk_en) begin
      irq_stat_r <= irq_stat_nxt;
      if (hit(acc, `IDX_IRQ_MASK) && acc.write) begin
        irq_mask_r <= wdata[3:0];
      end
    end
  end

  // Registered level interrupt from the next interrupt status and the mask.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // Pattern engine enables come straight from the enable register flops.
  assign pattern_checker_enable = ctrl_r[`CT_CHK];
  assign pattern_generator_enable = ctrl_r[`CT_GEN];

  // Status byte layout; bits 7 and 6 read zero.
  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_SD] = signal_present_live;
    status_byte[`ST_LOCK] = clock_recovery_locked_live;
    status_byte[`ST_LOCK_EV] = flags_r[2];
    status_byte[`ST_SD_EV] = flags_r[1];
    status_byte[`ST_RANGE] = eye_range_limit_error_r;
    status_byte[`ST_EYE_EV] = flags_r[0];
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    rdata = 32'h0000_0000;
    if (acc.mapped) begin
      unique case (acc.index)
        `IDX_THRESH: rdata[7:0] = thresh_r;
        `IDX_STATUS: rdata[7:0] = status_byte;
        `IDX_CTRL: rdata[7:0] = ctrl_r;
        `IDX_SPARE: rdata[7:0] = spare_r;
        `IDX_IRQ_STAT: rdata[3:0] = irq_stat_r;
        `IDX_IRQ_MASK: rdata[3:0] = irq_mask_r;
        `IDX_EYE_CFG: rdata[0] = eye_flag_enable_r;
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  // Live status follows the pin two enabled edges later.
  a_sd_live_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(clk_en) && $past(clk_en, 2) && $past(hresetn) && $past(hresetn, 2)) |->
      status_byte[`ST_SD] == $past(signal_present_pin, 2))
    else $error("signal detect status does not follow the pin");

  a_lock_live_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(clk_en) && $past(clk_en, 2) && $past(hresetn) && $past(hresetn, 2)) |->
      status_byte[`ST_LOCK] == $past(clock_recovery_locked_pin, 2))
    else $error("lock status does not follow the pin");

  // A rising lock with its enable raises the lock flag.
  a_lock_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && $rose(clock_recovery_locked_live) && ctrl_r[`CT_LOCK_EN] &&
     $past(clk_en)) |=> status_byte[`ST_LOCK_EV])
    else $error("lock flag not raised on lock rise");

  // Either edge of signal detect with its enable raises the detect flag.
  a_sd_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && (signal_present_live != sd_prev_r) && ctrl_r[`CT_SD_EN]) |=>
      status_byte[`ST_SD_EV])
    else $error("detect flag not raised on detect change");

  // A low vertical eye opening after lock with the enable set raises the eye flag.
  a_eye_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && eye_flag_enable_r && eye_sample.valid &&
     clock_recovery_locked_live &&
     (eye_sample.vertical < thresh_r[7:4])) |=> status_byte[`ST_EYE_EV])
    else $error("eye flag not raised on low vertical opening");

  // Without a status read a raised lock flag holds for three cycles.
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (flags_r[2] && !clr_status) |=> flags_r[2] ##1 (flags_r[2] || $past(clr_status)))
    else $error("event flag dropped without a read");

  // Range error follows the request during adaptation one cycle later.
  a_range_err_level: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && eye_measure_request && adaptation_busy) |=>
      status_byte[`ST_RANGE])
    else $error("range error not raised");

  // A write to the enable register drives the checker enable next cycle.
  a_checker_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && hit(acc, `IDX_CTRL) && acc.write) |=>
      pattern_checker_enable == $past(wdata[`CT_CHK]))
    else $error("checker enable does not follow its write");

  a_generator_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && hit(acc, `IDX_CTRL) && acc.write) |=>
      pattern_generator_enable == $past(wdata[`CT_GEN]))
    else $error("generator enable does not follow its write");

  // With the lock enable clear, a clear lock flag stays clear.
  a_lock_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ctrl_r[`CT_LOCK_EN] && !flags_r[2]) |=> !flags_r[2])
    else $error("lock flag raised while disabled");

  a_sd_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ctrl_r[`CT_SD_EN] && !flags_r[1]) |=> !flags_r[1])
    else $error("detect flag raised while disabled");

  // A status read in the event cycle leaves the flag set.
  a_set_beats_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (clr_status && (set_lock || set_sd || set_eye)) |=>
      ((flags_r & $past({set_lock, set_sd, set_eye})) == $past({set_lock, set_sd, set_eye})))
    else $error("event lost in the clearing read cycle");

endmodule
`default_nettype wire

// >>> rtl/retimer_consts.svh
// Purpose: Register indices, field positions and reset values of the channel status block.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only.
`ifndef RETIMER_CONSTS_SVH
`define RETIMER_CONSTS_SVH

// Register indices.
`define IDX_THRESH 8'h76
`define IDX_STATUS 8'h78
`define IDX_CTRL 8'h79
`define IDX_SPARE 8'h7a
`define IDX_IRQ_STAT 8'h80
`define IDX_IRQ_MASK 8'h81
`define IDX_EYE_CFG 8'h82

// Status register fields.
`define ST_SD 5
`define ST_LOCK 4
`define ST_LOCK_EV 3
`define ST_SD_EV 2
`define ST_RANGE 1
`define ST_EYE_EV 0

// Enable register fields.
`define CT_CHK 6
`define CT_GEN 5
`define CT_LOCK_EN 1
`define CT_SD_EN 0

// Interrupt status and mask fields.
`define IRQ_LOCK 0
`define IRQ_SD 1
`define IRQ_EYE 2
`define IRQ_RANGE 3

// Reset values.
`define RST_THRESH 8'h21
`define RST_CTRL 8'h10
`define RST_SPARE 8'h00
`define RST_MASK 4'h0

`endif

// >>> rtl/retimer_pkg.sv
// Purpose: Types shared by the channel status block and its bus port.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes: Constants live in the header.
package retimer_pkg;

  // One register access, valid for a single enabled cycle.
  typedef struct packed {
    logic valid;
    logic write;
    logic mapped;
    logic [7:0] index;
  } reg_access_t;

  // One eye opening measurement from the eye monitor.
  typedef struct packed {
    logic valid;
    logic [3:0] horizontal;
    logic [3:0] vertical;
  } eye_sample_t;

  // Phases of the bus port.
  typedef enum logic [1:0] {
    ph_idle,
    ph_wait,
    ph_done
  } bus_phase_t;

endpackage
